/* design/asc_pkg.sv */
// Package of constants and carrier types for analog and pulse I/O scaling
package asc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;            // 250 MHz
	localparam longint FILT_UNIT_PS = 64'd10_000_000_000; // 10 ms
	localparam int FILT_UNIT_CYCLES = int'(FILT_UNIT_PS / CLK_PERIOD_PS);

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CURVE_SEL   = 8'h00;
	localparam logic [7:0] ADDR_PAR_FIRST   = 8'h04; // idx 1 .. 15
	localparam logic [7:0] ADDR_PAR_LAST    = 8'h3c;
	localparam logic [7:0] ADDR_AO_SRC      = 8'h54;
	localparam logic [7:0] ADDR_PO_SRC      = 8'h60;
	localparam logic [7:0] ADDR_AO_RANGE    = 8'h64;
	localparam logic [7:0] ADDR_AO_GAIN     = 8'h70;
	localparam logic [7:0] ADDR_AO_OFFSET   = 8'h7c;
	localparam logic [7:0] ADDR_PO_MAX      = 8'h88;
	localparam logic [7:0] ADDR_PO_MIN      = 8'h8c;
	localparam logic [7:0] ADDR_PHYS_FIRST  = 8'h90;
	localparam logic [7:0] ADDR_PHYS_SECOND = 8'h94;
	localparam logic [7:0] ADDR_PHYS_PULSE  = 8'h98;
	localparam logic [7:0] ADDR_AO_LEVEL    = 8'h9c;
	localparam logic [7:0] ADDR_PO_FREQ     = 8'ha0;

	// ------------------------------------------------------------
	// Parameter indices inside the channel parameter array
	// ------------------------------------------------------------
	localparam int IX_A1_XMIN = 1;
	localparam int IX_A1_YMIN = 2;
	localparam int IX_A1_XMAX = 3;
	localparam int IX_A1_YMAX = 4;
	localparam int IX_A1_FILT = 5;
	localparam int IX_A2_XMIN = 6;
	localparam int IX_A2_YMIN = 7;
	localparam int IX_A2_XMAX = 8;
	localparam int IX_A2_YMAX = 9;
	localparam int IX_A2_FILT = 10;
	localparam int IX_PI_XMIN = 11;
	localparam int IX_PI_YMIN = 12;
	localparam int IX_PI_XMAX = 13;
	localparam int IX_PI_YMAX = 14;
	localparam int IX_PI_FILT = 15;

	// ------------------------------------------------------------
	// Limits (volts in 10 mV, kHz in 10 Hz, % in 0.1 %, s in 10 ms)
	// ------------------------------------------------------------
	localparam logic [15:0] AIN_X_LIMIT   = 16'h044c; // 11.00 V
	localparam logic [15:0] PIN_X_LIMIT   = 16'h1388; // 50.00 kHz
	localparam logic [15:0] PHYS_LIMIT    = 16'h03e8; // 100.0 %
	localparam logic [15:0] FILT_MIN      = 16'h0001; // 0.01 s
	localparam logic [15:0] FILT_MAX      = 16'h1388; // 50.00 s
	localparam logic [15:0] GAIN_LIMIT    = 16'h03e8; // 10.00
	localparam logic [15:0] OFFSET_LIMIT  = 16'h03e8; // 100.0 %
	localparam logic [15:0] PO_FREQ_LIMIT = 16'h1388; // 50.00 kHz
	localparam logic [3:0]  SRC_CODE_MAX  = 4'he;
	localparam logic [1:0]  CURVE_MAX     = 2'h3;
	localparam logic [15:0] STD_FULL      = 16'h03e8; // 10 V full scale
	localparam logic [15:0] STD_CAL_LEVEL = 16'h01f4; // 5 V
	localparam logic [15:0] RANGE1_BASE   = 16'h00c8; // 2 V
	localparam logic [3:0]  SRC_CAL       = 4'h5;
	localparam logic [3:0]  SRC_AIN_FIRST = 4'h9;
	localparam logic [3:0]  SRC_AIN_SECOND = 4'ha;

	// ------------------------------------------------------------
	// Reset values and curve defaults
	// ------------------------------------------------------------
	localparam logic [15:0] RST_AIN_XMIN  = 16'h0005; // 0.05 V
	localparam logic [15:0] RST_AIN_XMAX  = 16'h03e8; // 10.00 V
	localparam logic [15:0] RST_PIN_XMIN  = 16'h0000;
	localparam logic [15:0] RST_PIN_XMAX  = 16'h1388; // 50.00 kHz
	localparam logic [15:0] RST_YMIN      = 16'h0000; // 0.0 %
	localparam logic [15:0] RST_YMAX      = 16'h03e8; // 100.0 %
	localparam logic [15:0] RST_FILT      = 16'h0005; // 0.05 s
	localparam logic [15:0] RST_GAIN      = 16'h0064; // 1.00
	localparam logic [15:0] RST_PO_MAX    = 16'h03e8; // 10.00 kHz
	localparam logic [15:0] CRV_AIN_STEP  = 16'h00c8; // 2.00 V
	localparam logic [15:0] CRV_PIN_STEP  = 16'h03e8; // 10.00 kHz
	localparam logic [15:0] CRV_Y_STEP    = 16'h00c8; // 20.0 %

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] ain_first;  // 10 mV units
		logic [15:0] ain_second; // 10 mV units
		logic [15:0] pulse_in;   // 10 Hz units
	} asc_in_t;

	typedef struct packed {
		logic signed [15:0] first;
		logic signed [15:0] second;
		logic signed [15:0] pulse;
	} asc_phys_t;

	typedef logic [14:0][15:0] asc_std_t; // per source code, 0..1000

endpackage

/* design/asc_scaling.sv */
// Analog and pulse I/O scaling core with AXI4-Lite register slave
// Summary of operation
// R1: Curve select 0..3, default none
// R2: Select 0: three independent linear channels
// R3: Nonzero: selected channel only, others zero
// R4: Analog curve defaults 0..10 V, 2 V steps
// R5: Pulse curve defaults 0..50 kHz, linear physical
// R6: Defaults load only on committed select change
// R7: First input min/max limits and defaults
// R8: Physical values within +-100 %, defaults 0/100
// R9: Filter constant 0.01..50 s, default 0.05
// R10: Second input min/max limits and defaults
// R11: Pulse input limits, max physical 0..100 %
// R12: Linear mode clamps input to min/max
// R13: Software keeps max above min
// R14: Six ascending breakpoints define nonlinear curve
// R15: Digital low-pass filter per input
// R16: Analog out source 0..14, code 5 half scale
// R17: Pulse out source uses same codes
// R18: Output range 0-10 V or 2-10 V
// R19: Gain -10..10, default 1, immediate
// R20: Output equals gain times standard plus offset
// R21: Pulse out max/min frequency limits
// R22: Interpolate between breakpoints, clamp ends
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module asc_scaling
	import asc_pkg::*;
#(
	parameter int TICK_CYCLES = FILT_UNIT_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire asc_in_t     in_level,
	input  wire asc_std_t    std_level,
	output asc_phys_t        phys_out,
	output logic [15:0]      analog_out_level,
	output logic [15:0]      pulse_out_freq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]          curve_select;
		logic [15:1][15:0]   par;
		logic [3:0]          analog_out_source_sel;
		logic [3:0]          pulse_out_source_sel;
		logic                analog_out_range_sel;
		logic [15:0]         analog_out_gain;
		logic [15:0]         analog_out_offset;
		logic [15:0]         pulse_out_max_freq;
		logic [15:0]         pulse_out_min_freq;
		logic [2:0][23:0]    acc;
		logic [31:0]         tick;
		logic [15:0]         ao_lvl;
		logic [15:0]         po_freq;
		logic                aw_hold;
		logic [7:0]          awaddr;
		logic                w_hold;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} asc_state_t;

	asc_state_t st_q;
	asc_state_t st_d;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic signed [16:0] sx(input logic [15:0] v);
		return {v[15], v};
	endfunction

	function automatic logic signed [16:0] ux(input logic [15:0] v);
		return {1'b0, v};
	endfunction

	// Two-point map with input clamped to the end points
	function automatic logic signed [15:0] interp(
		input logic signed [16:0] x,
		input logic signed [16:0] x0,
		input logic signed [16:0] x1,
		input logic signed [16:0] y0,
		input logic signed [16:0] y1
	);
		logic signed [16:0] xc;
		logic signed [31:0] num;
		logic signed [31:0] r;
		xc = (x < x0) ? x0 : ((x > x1) ? x1 : x); // R12 R22
		if (x1 <= x0) begin
			r = 32'(y0);
		end else begin
			num = 32'(xc - x0) * 32'(y1 - y0);
			r = 32'(y0) + num / 32'(x1 - x0); // R22
		end
		return r[15:0];
	endfunction

	// Six-point curve built from all three parameter sets
	function automatic logic signed [15:0] curve6(
		input logic signed [16:0] x,
		input logic [15:1][15:0] p
	);
		logic signed [5:0][16:0] xs;
		logic signed [5:0][16:0] ys;
		logic signed [15:0] y;
		xs = {ux(p[IX_PI_XMAX]), ux(p[IX_PI_XMIN]), ux(p[IX_A2_XMAX]),
			ux(p[IX_A2_XMIN]), ux(p[IX_A1_XMAX]), ux(p[IX_A1_XMIN])}; // R14
		ys = {sx(p[IX_PI_YMAX]), sx(p[IX_PI_YMIN]), sx(p[IX_A2_YMAX]),
			sx(p[IX_A2_YMIN]), sx(p[IX_A1_YMAX]), sx(p[IX_A1_YMIN])};
		y = ys[0][15:0];
		for (int i = 0; i < 5; i++) begin
			if (x > xs[i]) begin
				y = interp(x, xs[i], xs[i+1], ys[i], ys[i+1]); // R22
			end
		end
		return y;
	endfunction

	// Signed range check against a symmetric limit
	function automatic logic in_sym(input logic [15:0] v,
		input logic [15:0] lim);
		return (sx(v) >= -ux(lim)) && (sx(v) <= ux(lim));
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic [31:0]        wv;
	logic [5:0]         widx;
	logic               wok;
	logic               do_wr;
	logic [2:0][15:0]   xin;
	logic signed [2:0][15:0] tgt;
	logic signed [24:0] diff;
	logic signed [24:0] step;
	logic [15:0]        tau;
	logic [15:0]        std_x;
	logic [15:0]        po_x;
	logic signed [31:0] ao_y;
	logic [31:0]        po_f;
	logic [1:0]         sel_ch;

	always_comb begin
		st_d = st_q;
		wv = '0;
		widx = '0;
		wok = 1'b0;
		do_wr = 1'b0;
		diff = '0;
		step = '0;
		tau = '0;
		ao_y = '0;
		po_f = '0;
		std_x = '0;
		po_x = '0;
		sel_ch = st_q.curve_select - 2'h1;

		// Address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_d.aw_hold = 1'b1;
			st_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_d.w_hold = 1'b1;
			st_d.wdata = s_axi_wdata;
			st_d.wstrb = s_axi_wstrb;
		end

		// Write once both halves are held; illegal values are refused
		if (st_q.aw_hold && st_q.w_hold && !st_q.bvalid) begin
			do_wr = 1'b1;
			widx = st_q.awaddr[7:2];
			for (int b = 0; b < 4; b++) begin
				wv[b*8 +: 8] = st_q.wstrb[b] ? st_q.wdata[b*8 +: 8] : 8'h00;
			end
			case (st_q.awaddr)
				ADDR_CURVE_SEL: begin
					wok = wv[15:0] <= 16'(CURVE_MAX); // R1
					if (wok && wv[1:0] != st_q.curve_select
						&& wv[1:0] != 2'h0) begin
						// Fresh breakpoints only on a real change
						for (int k = 0; k < 6; k++) begin
							st_d.par[(k / 2) * 5 + (k % 2) * 2 + 1] =
								16'(k) * ((wv[1:0] == CURVE_MAX) ?
								CRV_PIN_STEP : CRV_AIN_STEP); // R4 R5 R6
							st_d.par[(k / 2) * 5 + (k % 2) * 2 + 2] =
								16'(k) * CRV_Y_STEP; // R5
						end
					end
					if (wok) st_d.curve_select = wv[1:0];
				end
				ADDR_AO_SRC: begin
					wok = wv[15:0] <= 16'(SRC_CODE_MAX); // R16
					if (wok) st_d.analog_out_source_sel = wv[3:0];
				end
				ADDR_PO_SRC: begin
					wok = wv[15:0] <= 16'(SRC_CODE_MAX); // R17
					if (wok) st_d.pulse_out_source_sel = wv[3:0];
				end
				ADDR_AO_RANGE: begin
					wok = wv[15:0] <= 16'h0001; // R18
					if (wok) st_d.analog_out_range_sel = wv[0];
				end
				ADDR_AO_GAIN: begin
					wok = in_sym(wv[15:0], GAIN_LIMIT); // R19
					if (wok) st_d.analog_out_gain = wv[15:0];
				end
				ADDR_AO_OFFSET: begin
					wok = in_sym(wv[15:0], OFFSET_LIMIT); // R20
					if (wok) st_d.analog_out_offset = wv[15:0];
				end
				ADDR_PO_MAX: begin
					wok = wv[15:0] <= PO_FREQ_LIMIT
						&& wv[15:0] >= st_q.pulse_out_min_freq; // R21
					if (wok) st_d.pulse_out_max_freq = wv[15:0];
				end
				ADDR_PO_MIN: begin
					wok = wv[15:0] <= st_q.pulse_out_max_freq; // R21
					if (wok) st_d.pulse_out_min_freq = wv[15:0];
				end
				default: begin
					if (st_q.awaddr >= ADDR_PAR_FIRST
						&& st_q.awaddr <= ADDR_PAR_LAST) begin
						case ((widx - 6'd1) % 6'd5)
							6'd0: wok = wv[15:0] <=
								st_q.par[widx + 6'd2]; // R7 R10 R11
							6'd2: wok = wv[15:0] >= st_q.par[widx - 6'd2]
								&& wv[15:0] <= ((widx == 6'(IX_PI_XMAX))
								? PIN_X_LIMIT : AIN_X_LIMIT); // R7 R10 R11
							6'd4: wok = wv[15:0] >= FILT_MIN
								&& wv[15:0] <= FILT_MAX; // R9
							default: wok = (widx == 6'(IX_PI_YMAX))
								? wv[15:0] <= PHYS_LIMIT
								: in_sym(wv[15:0], PHYS_LIMIT); // R8 R11
						endcase
						if (wok) st_d.par[widx[3:0]] = wv[15:0];
					end
				end
			endcase
			st_d.aw_hold = 1'b0;
			st_d.w_hold = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = wok ? 2'b00 : 2'b10;
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end

		// Read path: one word per address, unmapped answers SLVERR
		if (s_axi_arvalid && s_axi_arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = 2'b00;
			st_d.rdata = '0;
			case (s_axi_araddr)
				ADDR_CURVE_SEL:   st_d.rdata = 32'(st_q.curve_select);
				ADDR_AO_SRC:      st_d.rdata = 32'(st_q.analog_out_source_sel);
				ADDR_PO_SRC:      st_d.rdata = 32'(st_q.pulse_out_source_sel);
				ADDR_AO_RANGE:    st_d.rdata = 32'(st_q.analog_out_range_sel);
				ADDR_AO_GAIN:     st_d.rdata = 32'(st_q.analog_out_gain);
				ADDR_AO_OFFSET:   st_d.rdata = 32'(st_q.analog_out_offset);
				ADDR_PO_MAX:      st_d.rdata = 32'(st_q.pulse_out_max_freq);
				ADDR_PO_MIN:      st_d.rdata = 32'(st_q.pulse_out_min_freq);
				ADDR_PHYS_FIRST:  st_d.rdata = 32'(st_q.acc[0][23:8]);
				ADDR_PHYS_SECOND: st_d.rdata = 32'(st_q.acc[1][23:8]);
				ADDR_PHYS_PULSE:  st_d.rdata = 32'(st_q.acc[2][23:8]);
				ADDR_AO_LEVEL:    st_d.rdata = 32'(st_q.ao_lvl);
				ADDR_PO_FREQ:     st_d.rdata = 32'(st_q.po_freq);
				default: begin
					if (s_axi_araddr >= ADDR_PAR_FIRST
						&& s_axi_araddr <= ADDR_PAR_LAST
						&& s_axi_araddr[1:0] == 2'b00) begin
						st_d.rdata = 32'(st_q.par[s_axi_araddr[5:2]]);
					end else begin
						st_d.rresp = 2'b10;
					end
				end
			endcase
		end else if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end

		// Input mapping: independent lines or one shared curve
		xin = {in_level.pulse_in, in_level.ain_second, in_level.ain_first};
		for (int c = 0; c < 3; c++) begin
			if (st_q.curve_select == 2'h0) begin
				tgt[c] = interp(ux(xin[c]), ux(st_q.par[c*5+1]),
					ux(st_q.par[c*5+3]), sx(st_q.par[c*5+2]),
					sx(st_q.par[c*5+4])); // R2 R12
			end else if (2'(c) == sel_ch) begin
				tgt[c] = curve6(ux(xin[c]), st_q.par); // R3 R14
			end else begin
				tgt[c] = '0; // R3
			end
		end

		// First-order low-pass, one step per filter time unit
		st_d.tick = (st_q.tick >= 32'(TICK_CYCLES - 1)) ? '0
			: st_q.tick + 32'd1;
		for (int c = 0; c < 3; c++) begin
			if (st_q.tick == '0) begin
				tau = st_q.par[c*5+5]; // R9 R15
				diff = 25'(signed'({tgt[c], 8'h00}))
					- 25'(signed'(st_q.acc[c])); // Negative targets pull down
				step = diff / signed'(25'(tau)); // R15
				// Truncation would stall short of target, so nudge
				if (step == '0 && diff != '0) begin
					step = diff[24] ? -25'sd1 : 25'sd1;
				end
				st_d.acc[c] = st_q.acc[c] + step[23:0];
			end
		end

		// Analog output: y = k*x + 10*b, then range mapping
		case (st_q.analog_out_source_sel)
			4'h0:           std_x = '0;
			SRC_CAL:        std_x = STD_CAL_LEVEL; // R16
			SRC_AIN_FIRST:  std_x = in_level.ain_first;
			SRC_AIN_SECOND: std_x = in_level.ain_second;
			default:        std_x = std_level[st_q.analog_out_source_sel];
		endcase
		ao_y = 32'(signed'(st_q.analog_out_gain)) * 32'(ux(std_x)) / 32'sd100
			+ 32'(signed'(st_q.analog_out_offset)); // R19 R20
		if (ao_y < 0) ao_y = '0;
		if (ao_y > 32'(STD_FULL)) ao_y = 32'(STD_FULL);
		if (st_q.analog_out_range_sel) begin
			ao_y = 32'(RANGE1_BASE) + ao_y * 32'(STD_FULL - RANGE1_BASE)
				/ 32'(STD_FULL); // R18
		end
		st_d.ao_lvl = ao_y[15:0];

		// Pulse output: source scaled between min and max frequency
		case (st_q.pulse_out_source_sel)
			4'h0:           po_x = '0;
			SRC_CAL:        po_x = STD_CAL_LEVEL;
			SRC_AIN_FIRST:  po_x = in_level.ain_first;
			SRC_AIN_SECOND: po_x = in_level.ain_second;
			default:        po_x = std_level[st_q.pulse_out_source_sel]; // R17
		endcase
		if (po_x > STD_FULL) po_x = STD_FULL;
		po_f = 32'(st_q.pulse_out_min_freq) + 32'(po_x)
			* 32'(st_q.pulse_out_max_freq - st_q.pulse_out_min_freq)
			/ 32'(STD_FULL); // R21
		st_d.po_freq = po_f[15:0];
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
			st_q.par[IX_A1_XMIN] <= RST_AIN_XMIN; // R7
			st_q.par[IX_A1_YMIN] <= RST_YMIN;     // R8
			st_q.par[IX_A1_XMAX] <= RST_AIN_XMAX;
			st_q.par[IX_A1_YMAX] <= RST_YMAX;
			st_q.par[IX_A1_FILT] <= RST_FILT;     // R9
			st_q.par[IX_A2_XMIN] <= RST_AIN_XMIN; // R10
			st_q.par[IX_A2_YMIN] <= RST_YMIN;
			st_q.par[IX_A2_XMAX] <= RST_AIN_XMAX;
			st_q.par[IX_A2_YMAX] <= RST_YMAX;
			st_q.par[IX_A2_FILT] <= RST_FILT;
			st_q.par[IX_PI_XMIN] <= RST_PIN_XMIN; // R11
			st_q.par[IX_PI_YMIN] <= RST_YMIN;
			st_q.par[IX_PI_XMAX] <= RST_PIN_XMAX;
			st_q.par[IX_PI_YMAX] <= RST_YMAX;
			st_q.par[IX_PI_FILT] <= RST_FILT;
			st_q.analog_out_gain <= RST_GAIN;     // R19
			st_q.pulse_out_max_freq <= RST_PO_MAX; // R21
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = !st_q.aw_hold && !st_q.bvalid;
	assign s_axi_wready = !st_q.w_hold && !st_q.bvalid;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign phys_out = {st_q.acc[0][23:8], st_q.acc[1][23:8],
		st_q.acc[2][23:8]};
	assign analog_out_level = st_q.ao_lvl;
	assign pulse_out_freq = st_q.po_freq;

endmodule // asc_scaling

`default_nettype wire

/* tb/asc_scaling_chk.sv */
// Checker of bus handshakes and output ranges for the scaling core
`timescale 1ns/1ps
`default_nettype none
module asc_scaling_chk
	import asc_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire asc_phys_t   phys_out,
	input wire logic [15:0] analog_out_level,
	input wire logic [15:0] pulse_out_freq
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Write taken on both channels, then two edges to the answer
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_resp;
		!s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
	endsequence
	wr_timing_a: assert property (wr_both |=> wr_resp)
		else $error("write answer late or early");
	rd_timing_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not one edge after take");
	aw_block_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answer pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	b_clear_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write answer not retired");
	r_clear_a: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid)
		else $error("read data not retired");
	ao_range_a: assert property (analog_out_level <= STD_FULL)
		else $error("analog level above full scale");
	po_range_a: assert property (pulse_out_freq <= PO_FREQ_LIMIT)
		else $error("pulse frequency above limit");
	phys_rng_a: assert property (phys_out.first <= 16'sh03e8
		&& phys_out.first >= -16'sh03e8)
		else $error("physical value out of range");
endmodule // asc_scaling_chk
bind asc_scaling asc_scaling_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.phys_out(phys_out), .analog_out_level(analog_out_level),
	.pulse_out_freq(pulse_out_freq));
`default_nettype wire

/* tb/asc_scaling_tb_top.sv */
// Self-checking bench for the analog and pulse scaling core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin \
	err_count++; $display("mismatch %0t %s", $time, m); end end
module asc_scaling_tb_top
	import asc_pkg::*;
;
	localparam logic [1:0] OK = 2'b00, SE = 2'b10;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [7:0]  awa, ara;
	logic [31:0] wd;
	logic [3:0]  ws;
	logic        awv, wv, bre, arv, rre;
	wire logic   awr, wrd, bvl, arr, rvl;
	wire logic [1:0]  brs, rrs;
	wire logic [31:0] rdt;
	asc_in_t     inl;
	asc_std_t    stdl;
	asc_phys_t   phy;
	logic [15:0] aol, pof;
	int          err_count = 0, checked = 0;
	// Expected reset and refusal tables, curve breakpoint indices
	logic [15:0] rv [1:15] = '{RST_AIN_XMIN, RST_YMIN, RST_AIN_XMAX,
		RST_YMAX, RST_FILT, RST_AIN_XMIN, RST_YMIN, RST_AIN_XMAX, RST_YMAX,
		RST_FILT, RST_PIN_XMIN, RST_YMIN, RST_PIN_XMAX, RST_YMAX, RST_FILT};
	logic [7:0]  oa [8] = '{8'h00, 8'h54, 8'h60, 8'h64, 8'h70, 8'h7c,
		8'h88, 8'h8c};
	logic [15:0] ov [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
		RST_GAIN, 16'h0000, RST_PO_MAX, 16'h0000};
	logic [7:0]  ba [17] = '{8'hfc, 8'h90, 8'h00, 8'h0c, 8'h20, 8'h34,
		8'h38, 8'h08, 8'h14, 8'h14, 8'h54, 8'h60, 8'h64, 8'h70, 8'h7c,
		8'h88, 8'h8c};
	logic [15:0] bd [17] = '{16'h0001, 16'h0000, 16'h0004, 16'h044d,
		16'h044d, 16'h1389, 16'hffff, 16'h03e9, 16'h0000, 16'h1389,
		16'h000f, 16'h000f, 16'h0002, 16'h03e9, 16'h03e9, 16'h1389,
		16'h03e9};
	int          xi [6] = '{1, 3, 6, 8, 11, 13};

	// Short filter tick keeps settling within a few tens of cycles
	asc_scaling #(.TICK_CYCLES(4)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bvl),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs),
		.s_axi_rvalid(rvl), .s_axi_rready(rre), .in_level(inl),
		.std_level(stdl), .phys_out(phy), .analog_out_level(aol),
		.pulse_out_freq(pof));

	always #2 aclk = ~aclk;

	function automatic logic [7:0] pa(input int i);
		return ADDR_PAR_FIRST + 8'(4 * (i - 1));
	endfunction
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Readies sampled mid-cycle; they only move after rising edges
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		logic b, ta, tw;
		logic [1:0] r;
		b = 1'b0;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			ta = awv && awr;
			tw = wv && wrd;
			b = bvl;
			r = brs;
			@(posedge aclk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		bre <= 1'b0;
		`CHK(r, e, "write response")
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] e);
		logic b, ta;
		logic [31:0] v;
		logic [1:0] r;
		b = 1'b0;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			ta = arv && arr;
			b = rvl;
			v = rdt;
			r = rrs;
			@(posedge aclk);
			if (ta) arv <= 1'b0;
		end
		rre <= 1'b0;
		`CHK(v, {16'h0000, d}, "read data")
		`CHK(r, e, "read response")
	endtask
	task automatic st;
		repeat (20) @(posedge aclk);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{aresetn, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
		ws = 4'hf;
		{inl, stdl} = '0;
		stdl[1] = 16'h012c;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_CURVE_SEL, 16'h0000, OK);
		for (int i = 1; i <= 15; i++) rd(pa(i), rv[i], OK);
		for (int i = 0; i < 8; i++) rd(oa[i], ov[i], OK);
		for (int i = 0; i < 17; i++) wr(ba[i], {16'h0, bd[i]}, SE);
		rd(8'hfc, 16'h0000, SE);
		rd(ADDR_AO_GAIN, RST_GAIN, OK);
		wr(pa(3), 32'h044c, OK);
		wr(pa(2), 32'hfc18, OK);
		rd(pa(2), 16'hfc18, OK);
		wr(pa(3), 32'h03e8, OK);
		ws <= 4'h1;
		wr(ADDR_AO_GAIN, 32'h01c8, OK);
		ws <= 4'hf;
		rd(ADDR_AO_GAIN, 16'h00c8, OK);
		wr(ADDR_AO_GAIN, 32'h0064, OK);
		// Linear mode, three channels on their own settings
		for (int i = 5; i <= 15; i += 5) wr(pa(i), 32'h1, OK);
		wr(pa(1), 32'h0, OK);
		wr(pa(6), 32'h0, OK);
		wr(pa(2), 32'hfe0c, OK);
		inl <= {16'h01f4, 16'h012c, 16'h09c4};
		st();
		`CHK(phy.first, 16'h00fa, "first linear")
		`CHK(phy.second, 16'h012c, "second linear")
		`CHK(phy.pulse, 16'h01f4, "pulse linear")
		wr(pa(1), 32'h64, OK);
		inl <= {16'h0032, 16'h012c, 16'h09c4};
		st();
		`CHK(phy.first, 16'hfe0c, "clamp at min")
		inl <= {16'h041a, 16'h012c, 16'h09c4};
		st();
		`CHK(phy.first, 16'h03e8, "clamp at max")
		// Curves on the first and pulse inputs, defaults and interpolation
		inl <= {16'h012c, 16'h012c, 16'h09c4};
		wr(ADDR_CURVE_SEL, 32'h1, OK);
		for (int k = 0; k < 6; k++) begin
			rd(pa(xi[k]), 16'(k) * CRV_AIN_STEP, OK);
			rd(pa(xi[k] + 1), 16'(k) * CRV_Y_STEP, OK);
		end
		st();
		`CHK(phy.first, 16'h012c, "curve first")
		`CHK(phy.second, 16'h0000, "unselected second")
		`CHK(phy.pulse, 16'h0000, "unselected pulse")
		wr(pa(4), 32'h64, OK);
		st();
		`CHK(phy.first, 16'h00fa, "curve interpolation")
		inl <= {16'h044c, 16'h012c, 16'h09c4};
		st();
		`CHK(phy.first, 16'h03e8, "curve end clamp")
		wr(ADDR_CURVE_SEL, 32'h1, OK);
		rd(pa(4), 16'h0064, OK);
		wr(ADDR_CURVE_SEL, 32'h3, OK);
		rd(pa(3), CRV_PIN_STEP, OK);
		rd(pa(4), CRV_Y_STEP, OK);
		st();
		`CHK(phy.pulse, 16'h01f4, "curve pulse")
		`CHK(phy.first, 16'h0000, "unselected first")
		// Long constant responds slowly, short one settles
		wr(pa(5), 32'h64, OK);
		inl <= {16'h03e8, 16'h012c, 16'h09c4};
		wr(ADDR_CURVE_SEL, 32'h0, OK);
		st();
		`CHK(phy.first == 16'h00c8, 1'b0, "slow filter")
		wr(pa(5), 32'h1, OK);
		st();
		`CHK(phy.first, 16'h00c8, "fast filter")
		rd(ADDR_PHYS_FIRST, 16'h00c8, OK);
		rd(ADDR_PHYS_SECOND, 16'h0190, OK);
		rd(ADDR_PHYS_PULSE, 16'h0320, OK);
		// Analog and pulse outputs
		wr(ADDR_AO_SRC, 32'h5, OK);
		st();
		`CHK(aol, STD_CAL_LEVEL, "calibration level")
		wr(ADDR_AO_GAIN, 32'hc8, OK);
		st();
		`CHK(aol, 16'h03e8, "gain applied")
		wr(ADDR_AO_GAIN, 32'hffce, OK);
		wr(ADDR_AO_OFFSET, 32'h0320, OK);
		st();
		`CHK(aol, 16'h0226, "gain and offset")
		wr(ADDR_AO_GAIN, 32'h64, OK);
		wr(ADDR_AO_OFFSET, 32'h0, OK);
		wr(ADDR_AO_RANGE, 32'h1, OK);
		st();
		`CHK(aol, 16'h0258, "live zero range")
		wr(ADDR_AO_RANGE, 32'h0, OK);
		wr(ADDR_AO_SRC, 32'h1, OK);
		st();
		`CHK(aol, 16'h012c, "standard source")
		wr(ADDR_PO_MAX, 32'h1388, OK);
		wr(ADDR_PO_MIN, 32'h03e8, OK);
		wr(ADDR_PO_SRC, 32'h1, OK);
		st();
		`CHK(pof, 16'h0898, "pulse scaled")
		wr(ADDR_PO_SRC, 32'h5, OK);
		st();
		`CHK(pof, 16'h0bb8, "pulse calibration")
		rd(ADDR_PO_FREQ, 16'h0bb8, OK);
		rd(ADDR_AO_LEVEL, 16'h012c, OK);
		summarize();
	end
	// Whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		summarize();
	end
endmodule // asc_scaling_tb_top
`default_nettype wire
